/* File: hsq_pkg.sv */
// constants, register map and types of the homing sequencer
package hsq_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned MS_PER_S      = 1000;
    localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_S;
    localparam int unsigned DEBOUNCE_US   = 100;
    localparam int unsigned US_PER_S      = 1_000_000;
    localparam int unsigned DEBOUNCE_CYC  = CLK_HZ / US_PER_S * DEBOUNCE_US;

    // register byte offsets
    localparam logic [5:0] OFS_CTRL   = 6'h00;
    localparam logic [5:0] OFS_METHOD = 6'h04;
    localparam logic [5:0] OFS_HSPD   = 6'h08;
    localparam logic [5:0] OFS_LSPD   = 6'h0C;
    localparam logic [5:0] OFS_TLIM   = 6'h10;
    localparam logic [5:0] OFS_OFFS   = 6'h14;
    localparam logic [5:0] OFS_STAT   = 6'h18;
    localparam logic [5:0] OFS_ORIG   = 6'h1C;
    localparam logic [5:0] OFS_POS    = 6'h20;

    // control and status bit positions
    localparam int CTRL_START = 0;
    localparam int CTRL_ABORT = 1;
    localparam int STAT_BUSY  = 0;
    localparam int STAT_DONE  = 1;
    localparam int STAT_TMO   = 2;
    localparam int STAT_BADM  = 3;
    localparam int STAT_LIMF  = 4;
    localparam int STAT_DIR   = 5;
    localparam int STAT_FAST  = 6;

    // reset values
    localparam logic [7:0]  RST_METHOD = 8'h06;
    localparam logic [15:0] RST_HSPD   = 16'h0064;
    localparam logic [15:0] RST_LSPD   = 16'h000A;
    localparam logic [15:0] RST_TLIM   = 16'h2710;
    localparam logic [31:0] RST_OFFS   = 32'h0000_0000;

    // supported method window
    localparam logic [7:0] METHOD_MIN = 8'h06;
    localparam logic [7:0] METHOD_MAX = 8'h0E;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEEK,
        ST_CROSS,
        ST_APPROACH,
        ST_EXIT,
        ST_INDEX,
        ST_DONE
    } hsq_state_t;

endpackage : hsq_pkg

/* File: hsq_sw_if.sv */
// raw and cleaned switch levels between top and debouncer
interface hsq_sw_if #(
    parameter int N = 3
);
    logic [N-1:0] raw;
    logic [N-1:0] clean;

    modport filter (input raw, output clean);
    modport user   (output raw, input clean);
endinterface : hsq_sw_if

/* File: hsq_debounce.sv */
// two-flop synchroniser and stability filter for switch inputs
module hsq_debounce #(
    parameter int N   = 3,
    parameter int CYC = hsq_pkg::DEBOUNCE_CYC
) (
    input  wire logic  aclk,
    input  wire logic  aresetn,
    hsq_sw_if.filter   sw
);
    localparam int CW = $clog2(CYC + 1);

    initial
    begin
        if (CYC < 1 || N < 1)
            $error("hsq_debounce: bad parameters");
    end

    ////////////////////////////////////////////////////////////////////
    // one synchroniser and counter per channel
    for (genvar i = 0; i < N; i++)
    begin : g_ch
        logic          s1_reg;
        logic          s2_reg;
        logic          out_reg;
        logic [CW-1:0] cnt_reg;
        wire           differs = s2_reg ^ out_reg;
        wire           settled = (cnt_reg == CW'(CYC - 1));

        // input only accepted after CYC stable cycles; bounce restarts
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                s1_reg  <= 1'b0;
                s2_reg  <= 1'b0;
                out_reg <= 1'b0;
                cnt_reg <= '0;
            end
            else
            begin
                s1_reg  <= sw.raw[i];
                s2_reg  <= s1_reg;
                cnt_reg <= (differs && !settled) ? cnt_reg + 1'b1 : '0;
                if (differs && settled)
                    out_reg <= s2_reg;
            end
        end

        assign sw.clean[i] = out_reg;
    end

endmodule : hsq_debounce

/* File: hsq_homing_top.sv */
// homing sequencer for methods 6 to 14 with axi4-lite registers
//
// Functional notes
// - method 6: cw switch edge, ccw index
// - method 6 path from on-switch start
// - method 7: ccw switch edge, ccw index
// - method 7 path, reverse on cw limit
// - method 8: ccw switch edge, cw index
// - method 8: cross switch fast, return slow
// - method 9: cw switch edge, ccw index
// - method 9: cross switch, reverse, reenter
// - method 10: cw switch edge, cw index
// - method 10: limit reverse, reverse at switch
// - method 11: cw edge, cw index, ccw first
// - method 11: reverse on switch, index after leaving
// - method 12: cw edge, ccw index, ccw first
// - method 12: ccw limit reverse, return slow
// - method 13: ccw edge, cw index, ccw first
// - method 13: cross switch, return slow, reenter
// - method 14: ccw edge, ccw index, ccw first
// - method 14: ccw limit reverse, reverse slow
// - reserved method value gives no motion
// - time limit raises homing timeout alarm
// - signed origin offset added to origin
module hsq_homing_top #(
    parameter int unsigned MS_CYC  = hsq_pkg::MS_CYCLES,
    parameter int unsigned DEB_CYC = hsq_pkg::DEBOUNCE_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        home_switch,
    input  wire logic        cw_limit,
    input  wire logic        ccw_limit,
    input  wire logic        encoder_index_pulse,
    input  wire logic [31:0] position,
    output logic             motor_run,
    output logic             motor_cw,
    output logic [15:0]      speed_cmd,
    output logic             homing_busy,
    output logic             homing_done,
    output logic             homing_timeout_alarm
);
    initial
    begin
        if (MS_CYC < 2 || DEB_CYC < 1)
            $error("hsq_homing_top: bad timing parameters");
    end

    // byte-lane merge used by every configuration register
    function automatic logic [31:0] hsq_merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                res[8*b +: 8] = data[8*b +: 8];
        return res;
    endfunction : hsq_merge

    // method table: {supported, first search cw, final cw, enter-type}
    function automatic logic [3:0] hsq_method(input logic [7:0] m);
        case (m)
            8'h06:   hsq_method = 4'b1001;
            8'h07:   hsq_method = 4'b1100;
            8'h08:   hsq_method = 4'b1111;
            8'h09:   hsq_method = 4'b1101;
            8'h0A:   hsq_method = 4'b1110;
            8'h0B:   hsq_method = 4'b1010;
            8'h0C:   hsq_method = 4'b1001;
            8'h0D:   hsq_method = 4'b1011;
            8'h0E:   hsq_method = 4'b1000;
            default: hsq_method = 4'b0000;
        endcase
    endfunction : hsq_method

    ////////////////////////////////////////////////////////////////////
    // input conditioning
    hsq_sw_if #(.N(3)) sw ();

    assign sw.raw = {ccw_limit, cw_limit, home_switch};

    hsq_debounce #(
        .N   (3),
        .CYC (DEB_CYC)
    ) u_deb (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sw      (sw)
    );

    wire home_on = sw.clean[0];
    wire cw_lim  = sw.clean[1];
    wire ccw_lim = sw.clean[2];

    // index is a short pulse, so only synchronised, not filtered
    logic idx_s1_reg;
    logic idx_s2_reg;
    logic idx_d_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            idx_s1_reg <= 1'b0;
            idx_s2_reg <= 1'b0;
            idx_d_reg  <= 1'b0;
        end
        else
        begin
            idx_s1_reg <= encoder_index_pulse;
            idx_s2_reg <= idx_s1_reg;
            idx_d_reg  <= idx_s2_reg;
        end
    end

    wire idx_rise = idx_s2_reg & ~idx_d_reg;

    ////////////////////////////////////////////////////////////////////
    // axi4-lite write path
    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        aw_have_reg;
    logic        w_have_reg;
    logic [5:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;

    wire aw_fire  = s_axi_awvalid & awready_reg;
    wire w_fire   = s_axi_wvalid & wready_reg;
    wire b_fire   = bvalid_reg & s_axi_bready;
    wire do_write = aw_have_reg & w_have_reg & ~bvalid_reg;

    // register selects of the pending write
    wire wr_ctrl = do_write && awaddr_reg == hsq_pkg::OFS_CTRL;
    wire wr_meth = do_write && awaddr_reg == hsq_pkg::OFS_METHOD;
    wire wr_hspd = do_write && awaddr_reg == hsq_pkg::OFS_HSPD;
    wire wr_lspd = do_write && awaddr_reg == hsq_pkg::OFS_LSPD;
    wire wr_tlim = do_write && awaddr_reg == hsq_pkg::OFS_TLIM;
    wire wr_offs = do_write && awaddr_reg == hsq_pkg::OFS_OFFS;
    wire wr_ro   = do_write && (awaddr_reg == hsq_pkg::OFS_STAT
                             || awaddr_reg == hsq_pkg::OFS_ORIG
                             || awaddr_reg == hsq_pkg::OFS_POS);
    wire wr_ok   = wr_ctrl | wr_meth | wr_hspd | wr_lspd | wr_tlim
                 | wr_offs | wr_ro;

    wire ctl_lane0 = wr_ctrl & wstrb_reg[0];
    wire start_cmd = ctl_lane0 & wdata_reg[hsq_pkg::CTRL_START];
    wire abort_cmd = ctl_lane0 & wdata_reg[hsq_pkg::CTRL_ABORT];

    // address and data taken in either order, one write at a time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= hsq_pkg::RESP_OKAY;
            awaddr_reg  <= '0;
            wdata_reg   <= '0;
            wstrb_reg   <= '0;
        end
        else
        begin
            if (aw_fire)
            begin
                awready_reg <= 1'b0;
                aw_have_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (w_fire)
            begin
                wready_reg <= 1'b0;
                w_have_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_ok ? hsq_pkg::RESP_OKAY
                                     : hsq_pkg::RESP_SLVERR;
            end
            if (b_fire)
            begin
                bvalid_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [7:0]  method_reg;
    logic [15:0] hspd_reg;
    logic [15:0] lspd_reg;
    logic [15:0] tlim_reg;
    logic [31:0] offs_reg;

    wire [31:0] mrg_meth = hsq_merge({24'h0, method_reg}, wdata_reg,
                                     wstrb_reg);
    wire [31:0] mrg_hspd = hsq_merge({16'h0, hspd_reg}, wdata_reg,
                                     wstrb_reg);
    wire [31:0] mrg_lspd = hsq_merge({16'h0, lspd_reg}, wdata_reg,
                                     wstrb_reg);
    wire [31:0] mrg_tlim = hsq_merge({16'h0, tlim_reg}, wdata_reg,
                                     wstrb_reg);
    wire [31:0] mrg_offs = hsq_merge(offs_reg, wdata_reg, wstrb_reg);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            method_reg <= hsq_pkg::RST_METHOD;
            hspd_reg   <= hsq_pkg::RST_HSPD;
            lspd_reg   <= hsq_pkg::RST_LSPD;
            tlim_reg   <= hsq_pkg::RST_TLIM;
            offs_reg   <= hsq_pkg::RST_OFFS;
        end
        else
        begin
            if (wr_meth) method_reg <= mrg_meth[7:0];
            if (wr_hspd) hspd_reg   <= mrg_hspd[15:0];
            if (wr_lspd) lspd_reg   <= mrg_lspd[15:0];
            if (wr_tlim) tlim_reg   <= mrg_tlim[15:0];
            if (wr_offs) offs_reg   <= mrg_offs;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // homing sequence
    hsq_pkg::hsq_state_t state_reg;
    hsq_pkg::hsq_state_t state_next;
    logic                dir_reg;
    logic                dir_next;
    logic                fast_reg;
    logic                fast_next;
    logic                limf_next;
    logic                tmo_hit;

    wire [3:0] mdec     = hsq_method(method_reg);
    wire       m_ok     = mdec[3];
    wire       first_cw = mdec[2];
    wire       final_cw = mdec[1];
    wire       enter_t  = mdec[0];
    wire       lim_ahead = dir_reg ? cw_lim : ccw_lim;
    wire       at_final  = (dir_reg == final_cw);
    wire       moving    = (state_reg != hsq_pkg::ST_IDLE)
                        && (state_reg != hsq_pkg::ST_DONE);

    // next-state logic of the search
    always_comb
    begin
        state_next = state_reg;
        dir_next   = dir_reg;
        fast_next  = fast_reg;
        limf_next  = 1'b0;
        if (start_cmd && m_ok)
        begin
            fast_next = !home_on;
            if (!home_on)
            begin
                state_next = hsq_pkg::ST_SEEK;
                dir_next   = first_cw;
            end
            else if (enter_t)
            begin
                // leave the switch away from the final side, then return
                state_next = hsq_pkg::ST_CROSS;
                dir_next   = !final_cw;
            end
            else
            begin
                state_next = hsq_pkg::ST_EXIT;
                dir_next   = final_cw;
            end
        end
        else if (start_cmd || abort_cmd || (moving && tmo_hit))
            state_next = hsq_pkg::ST_IDLE;
        else
        begin
            case (state_reg)
                hsq_pkg::ST_SEEK:
                    if (lim_ahead)
                        dir_next = !dir_reg;
                    else if (home_on && at_final)
                    begin
                        fast_next  = 1'b0;
                        state_next = enter_t ? hsq_pkg::ST_INDEX
                                             : hsq_pkg::ST_EXIT;
                    end
                    else if (home_on && enter_t)
                        state_next = hsq_pkg::ST_CROSS;
                    else if (home_on)
                    begin
                        fast_next  = 1'b0;
                        dir_next   = final_cw;
                        state_next = hsq_pkg::ST_EXIT;
                    end
                hsq_pkg::ST_CROSS:
                    if (!home_on)
                    begin
                        fast_next  = 1'b0;
                        dir_next   = final_cw;
                        state_next = hsq_pkg::ST_APPROACH;
                    end
                hsq_pkg::ST_APPROACH:
                    if (home_on)
                        state_next = hsq_pkg::ST_INDEX;
                hsq_pkg::ST_EXIT:
                    if (!home_on)
                        state_next = hsq_pkg::ST_INDEX;
                hsq_pkg::ST_INDEX:
                    if (idx_rise && at_final)
                        state_next = hsq_pkg::ST_DONE;
                default: ;
            endcase
            // a limit outside the search phase means a lost switch
            if (moving && state_reg != hsq_pkg::ST_SEEK && lim_ahead)
            begin
                state_next = hsq_pkg::ST_IDLE;
                limf_next  = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // elapsed time in milliseconds
    logic [$clog2(MS_CYC)-1:0] ms_cnt_reg;
    logic [15:0]               ms_elapsed_reg;

    wire ms_tick = (ms_cnt_reg == ($clog2(MS_CYC))'(MS_CYC - 1));

    // zero limit disables the watchdog
    assign tmo_hit = (tlim_reg != 16'h0000)
                  && (ms_elapsed_reg >= tlim_reg);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || start_cmd || !moving)
        begin
            ms_cnt_reg     <= '0;
            ms_elapsed_reg <= '0;
        end
        else
        begin
            ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 1'b1;
            if (ms_tick && ms_elapsed_reg != 16'hFFFF)
                ms_elapsed_reg <= ms_elapsed_reg + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state, flags and motor command
    logic        done_reg;
    logic        tmo_reg;
    logic        badm_reg;
    logic        limf_reg;
    logic        run_reg;
    logic [15:0] speed_reg;
    logic [31:0] origin_reg;

    wire run_next = (state_next != hsq_pkg::ST_IDLE)
                 && (state_next != hsq_pkg::ST_DONE);
    wire captured = (state_next == hsq_pkg::ST_DONE)
                 && (state_reg != hsq_pkg::ST_DONE);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg  <= hsq_pkg::ST_IDLE;
            dir_reg    <= 1'b0;
            fast_reg   <= 1'b0;
            run_reg    <= 1'b0;
            speed_reg  <= 16'h0000;
            done_reg   <= 1'b0;
            tmo_reg    <= 1'b0;
            badm_reg   <= 1'b0;
            limf_reg   <= 1'b0;
            origin_reg <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            dir_reg   <= dir_next;
            fast_reg  <= fast_next;
            run_reg   <= run_next;
            speed_reg <= !run_next ? 16'h0000
                       : fast_next ? hspd_reg : lspd_reg;
            done_reg  <= (done_reg & ~start_cmd) | captured;
            tmo_reg   <= (tmo_reg & ~start_cmd) | (moving & tmo_hit);
            badm_reg  <= start_cmd ? !m_ok : badm_reg;
            limf_reg  <= (limf_reg & ~start_cmd) | limf_next;
            if (captured)
                origin_reg <= position + offs_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi4-lite read path
    logic        arready_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    wire ar_fire = s_axi_arvalid & arready_reg;
    wire r_fire  = rvalid_reg & s_axi_rready;

    wire [31:0] stat_word = {25'h0, fast_reg, dir_reg, limf_reg,
                             badm_reg, tmo_reg, done_reg, run_reg};

    // read mux; unmapped offsets answer zero with an error
    logic [31:0] rd_mux;
    logic        rd_hit;

    always_comb
    begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            hsq_pkg::OFS_CTRL:   rd_mux = 32'h0000_0000;
            hsq_pkg::OFS_METHOD: rd_mux = {24'h0, method_reg};
            hsq_pkg::OFS_HSPD:   rd_mux = {16'h0, hspd_reg};
            hsq_pkg::OFS_LSPD:   rd_mux = {16'h0, lspd_reg};
            hsq_pkg::OFS_TLIM:   rd_mux = {16'h0, tlim_reg};
            hsq_pkg::OFS_OFFS:   rd_mux = offs_reg;
            hsq_pkg::OFS_STAT:   rd_mux = stat_word;
            hsq_pkg::OFS_ORIG:   rd_mux = origin_reg;
            hsq_pkg::OFS_POS:    rd_mux = position;
            default:
            begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= hsq_pkg::RESP_OKAY;
        end
        else if (ar_fire)
        begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_mux;
            rresp_reg   <= rd_hit ? hsq_pkg::RESP_OKAY
                                  : hsq_pkg::RESP_SLVERR;
        end
        else if (r_fire)
        begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all registered
    assign s_axi_awready        = awready_reg;
    assign s_axi_wready         = wready_reg;
    assign s_axi_bvalid         = bvalid_reg;
    assign s_axi_bresp          = bresp_reg;
    assign s_axi_arready        = arready_reg;
    assign s_axi_rvalid         = rvalid_reg;
    assign s_axi_rdata          = rdata_reg;
    assign s_axi_rresp          = rresp_reg;
    assign motor_run            = run_reg;
    assign motor_cw             = dir_reg;
    assign speed_cmd            = speed_reg;
    assign homing_busy          = run_reg;
    assign homing_done          = done_reg;
    assign homing_timeout_alarm = tmo_reg;

endmodule : hsq_homing_top

/* File: hsq_homing_checker.sv */
// port assertions for the homing sequencer
module hsq_homing_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        motor_run,
    input wire logic [15:0] speed_cmd,
    input wire logic        homing_busy,
    input wire logic        homing_done,
    input wire logic        homing_timeout_alarm
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_busy_run: assert property (homing_busy == motor_run)
        else $error("busy differs from run");
    a_idle_speed: assert property (!motor_run |-> speed_cmd == 16'h0000)
        else $error("speed while stopped");
    a_done_stop: assert property (homing_done |-> !motor_run)
        else $error("moving while done");
    a_alarm_stop: assert property (homing_timeout_alarm |-> !motor_run)
        else $error("moving after timeout");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped early");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready during response");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during response");
    a_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready)
        else $error("awready not back");
endmodule : hsq_homing_checker
bind hsq_homing_top hsq_homing_checker i_chk (.*);

/* File: hsq_world.sv */
// axis model: one count a cycle, switch window, limits, index every 16
module hsq_world (
    input  wire logic        aclk,
    input  wire logic        motor_run,
    input  wire logic        motor_cw,
    input  wire logic        load,
    input  wire logic [31:0] start_pos,
    output logic             home_switch,
    output logic             cw_limit,
    output logic             ccw_limit,
    output logic             encoder_index_pulse,
    output logic [31:0]      position = 32'h0000_0000
);
    timeunit 1ns;
    timeprecision 100ps;
    // speed is not modelled, only direction
    always @(posedge aclk)
        if (load) position <= start_pos;
        else if (motor_run) position <= motor_cw ? position + 1 : position - 1;
    assign home_switch = $signed(position) >= 100 && $signed(position) < 140;
    assign cw_limit = $signed(position) >= 300;
    assign ccw_limit = $signed(position) <= -300;
    assign encoder_index_pulse = motor_run && position[3:0] == 4'h0;
endmodule : hsq_world

/* File: homing_sequencer_modes_6_to_14_tb_top.sv */
// bench: register traffic and homing runs against the axis model
module homing_sequencer_modes_6_to_14_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 0, aresetn = 0, load = 1, last_cw, first_cw, run_d, aw, w, b;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, motor_run, motor_cw;
    logic homing_busy, homing_done, homing_timeout_alarm, home_switch;
    logic cw_limit, ccw_limit, encoder_index_pulse;
    logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, position, d, p, start_pos = 0;
    logic [15:0] speed_cmd, first_spd;
    int bad_count = 0, check_count = 0, n;
    always #12.5 aclk = ~aclk;
    hsq_homing_top #(.MS_CYC(10), .DEB_CYC(4)) i_dut (.*);
    hsq_world i_axis (.*);
    // first and last commanded direction of each run
    always @(posedge aclk) begin
        run_d <= motor_run;
        if (motor_run) last_cw <= motor_cw;
        if (motor_run && !run_d) {first_cw, first_spd} <= {motor_cw, speed_cmd};
    end
    task automatic chk(string nm, logic [31:0] s, e);
        check_count++;
        if (s !== e) begin bad_count++; $display("[ERR] %s exp %h got %h", nm, e, s); end
    endtask : chk
    // ready is sampled mid-cycle, it only moves on rising edges
    task automatic wr(logic [5:0] a, logic [31:0] v);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(negedge aclk); {aw, w, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            @(posedge aclk); if (aw) s_axi_awvalid <= 0; if (w) s_axi_wvalid <= 0;
        end while (!b);
        s_axi_bready <= 0;
    endtask : wr
    task automatic rd(logic [5:0] a, output logic [31:0] v);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(negedge aclk); {aw, b, v, rr} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk); if (aw) s_axi_arvalid <= 0;
        end while (!b);
        s_axi_rready <= 0;
    endtask : rd
    // park the axis off the switch, let the filters settle, then start
    task automatic go(logic [7:0] m);
        @(posedge aclk); load <= 1;
        repeat (10) @(posedge aclk); load <= 0;
        wr(hsq_pkg::OFS_METHOD, {24'h0, m}); wr(hsq_pkg::OFS_CTRL, 32'h1);
        n = 0;
    endtask : go
    task automatic summarize;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial begin repeat (60000) @(posedge aclk); bad_count++; summarize(); end
    initial begin
        repeat (10) @(posedge aclk);
        {aresetn, load} <= 2'b10;
        rd(hsq_pkg::OFS_METHOD, d); chk("method", d, 32'h6);
        rd(hsq_pkg::OFS_HSPD, d); chk("hspd", d, 32'h64);
        rd(hsq_pkg::OFS_TLIM, d); chk("tlim", d, 32'h2710);
        rd(6'h24, d); chk("resp", rr, 32'h2);
        wr(hsq_pkg::OFS_OFFS, 32'h5); wr(hsq_pkg::OFS_TLIM, 32'h0);
        for (int m = 6; m < 16; m++) begin
            go(m);
            if (m == 15) begin
                repeat (20) @(negedge aclk);
                chk("idle", {homing_done, motor_run}, 32'h0);
                rd(hsq_pkg::OFS_STAT, d); chk("bad", d[3], 32'h1);
            end else begin
                while (homing_done !== 1 && n++ < 4000) @(negedge aclk);
                chk("done", homing_done, 32'h1);
                chk("dir0", first_cw, m inside {[7:10]});
                chk("spd0", first_spd, 32'h64);
                chk("dir1", last_cw, m inside {8, 10, 11, 13});
                rd(hsq_pkg::OFS_ORIG, d); rd(hsq_pkg::OFS_POS, p);
                chk("orig", d - p - 4 < 3, 32'h1);
            end
        end
        wr(hsq_pkg::OFS_TLIM, 32'h1); go(7);
        while (homing_timeout_alarm !== 1 && n++ < 200) @(negedge aclk);
        chk("tmo", {homing_timeout_alarm, motor_run}, 32'h2);
        summarize();
    end
endmodule : homing_sequencer_modes_6_to_14_tb_top
